// ### rtl/isa_i2c_slave.sv
// I2C slave front end: strap-selected address, General Call software reset, identity read.
// Assumes SCL and SDA are open-drain lines resolved outside; sclIn/sdaIn are the wire levels.
// The system clock must be several times faster than SCL so that every bus edge is seen.

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Classify each strap as GND, VDD, SCL or SDA; answer the matching address.
// - Besides the own address, recognise the General Call and identification addresses.
// - Acknowledge the General Call address only as byte 00h, write direction.
// - General Call with read direction is not acknowledged.
// - One command byte follows; acknowledged only when it equals 06h.
// - A command byte other than 06h is not acknowledged and causes no reset.
// - Any byte after the reset command byte is not acknowledged.
// - STOP after the acknowledged command resets all state except the input synchronisers to power-up defaults.
// - A repeated START after the command byte cancels the reset.
// - A hard-wired read-only 24-bit identity word: manufacturer, part, revision.
// - Part field is 13 bits: 7-bit category above a 6-bit feature code.
// - Master then sends a slave address; only its owner acknowledges, LSB ignored.
// - Identity goes out manufacturer first, then part, revision last in low bits.
// - STOP between selection and read clears the selection; no identity read.
// - An access to another slave clears the selection; no identity read.
// - A master not-acknowledge ends the identity read and frees the bus.
// - Continued acknowledges wrap the identity back to its first byte.
// - The last address bit is the direction: one read, zero write.
module isa_i2c_slave #(
  parameter isa_pkg::isa_devid_s DEV_ID = 24'h5A_A5_3C // Arbitrary identity value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // I2C bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Address straps
  input wire logic addrStrap0,
  input wire logic addrStrap1,
  input wire logic addrStrap2,
  // Status towards the expander core
  output logic [6:0] slaveAddr,
  output logic addrValid,
  output logic softResetPulse,
  output logic ownAddrHit
);
  import isa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: bit 0 SCL, 1 SDA, 2..4 straps
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  logic [1:0] prevBus_ff, fill_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 5'h1F;
      sync_ff <= 5'h1F;
      prevBus_ff <= 2'h3;
      fill_ff <= 2'h0;
    end else begin
      meta_ff <= {addrStrap2, addrStrap1, addrStrap0, sdaIn, sclIn};
      sync_ff <= meta_ff;
      prevBus_ff <= sync_ff[1:0];
      // Marks when the synchronisers hold real pin levels, not their reset value
      fill_ff <= {fill_ff[0], 1'b1};
    end
  end

  wire sclS = sync_ff[0];
  wire sdaS = sync_ff[1];
  wire [2:0] strapS = sync_ff[4:2];
  wire prevScl = prevBus_ff[0];
  wire prevSda = prevBus_ff[1];

  isa_busev_s ev;
  assign ev.start = sclS & prevScl & prevSda & ~sdaS;
  assign ev.stop = sclS & prevScl & ~prevSda & sdaS;
  assign ev.sclRise = sclS & ~prevScl;
  assign ev.sclFall = ~sclS & prevScl;

  ////////////////////////////////////////////////////////////////////////////////
  // Strap classification
  // A strap on SCL and one on VDD look alike until SCL first falls, so the decision
  // waits for the first SCL fall after the first START; the address byte is still in flight.
  logic [11:0] misFlags_ff;
  logic seenStart_ff;
  logic addrValid_ff;
  logic [6:0] slaveAddr_ff;
  logic swRst_ff;
  wire [11:0] misNow;
  isa_tie_e tie [3];
  wire [2:0] hiIdx;
  wire [2:0] loBits;
  // Current levels count too, so an SCL strap is seen low at the very fall that latches
  wire [11:0] misAll = misFlags_ff | misNow;

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_strap
      // Flags: 0 seen high, 1 seen low, 2 differs from SCL, 3 differs from SDA
      assign misNow[k*4 +: 4] = {strapS[k] ^ sdaS, strapS[k] ^ sclS, ~strapS[k], strapS[k]};
      assign tie[k] = !misAll[k*4] ? TIE_GND :
                      !misAll[k*4+1] ? TIE_VDD :
                      !misAll[k*4+2] ? TIE_SCL : TIE_SDA;
      assign hiIdx[k] = tie[k][1];
      assign loBits[k] = tie[k][0];
    end
  endgenerate

  wire [3:0] addrHi = ADDR_HI_TAB[{hiIdx, 2'b00} +: 4];
  wire [6:0] strapAddr = {addrHi, loBits};
  wire latchAddr = seenStart_ff & ev.sclFall & ~addrValid_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      misFlags_ff <= MIS_RST;
      seenStart_ff <= 1'b0;
      addrValid_ff <= 1'b0;
      slaveAddr_ff <= ADDR_RST;
    end else if (swRst_ff) begin
      misFlags_ff <= MIS_RST;
      seenStart_ff <= 1'b0;
      addrValid_ff <= 1'b0;
      slaveAddr_ff <= ADDR_RST;
    end else begin
      if (!addrValid_ff && fill_ff[1]) begin
        misFlags_ff <= misFlags_ff | misNow;
      end
      if (ev.start) begin
        seenStart_ff <= 1'b1;
      end
      if (latchAddr) begin
        addrValid_ff <= 1'b1;
        slaveAddr_ff <= strapAddr;
      end
    end
  end

  // Own address is usable only once decoded and when it is not a reserved one
  wire ownOk = addrValid_ff & (slaveAddr_ff != GC_ADDR) & (slaveAddr_ff != ID_ADDR);

  ////////////////////////////////////////////////////////////////////////////////
  // Byte decisions
  isa_state_e state_ff, nxt_state;
  isa_ctx_e ctx_ff, nxt_ctx;
  logic [3:0] bitCnt_ff, nxt_bitCnt;
  logic [7:0] shift_ff, nxt_shift;
  logic sdaOe_ff, nxt_sdaOe;
  logic gcArmed_ff, nxt_gcArmed;
  logic idArmed_ff, nxt_idArmed;
  logic [1:0] idIdx_ff, nxt_idIdx;
  logic mackNack_ff, nxt_mackNack;
  logic nxt_swRst;
  logic ownHit_ff, nxt_ownHit;

  wire [6:0] rxAddr = shift_ff[7:1];
  wire rxRead = shift_ff[0];
  wire isGc = (rxAddr == GC_ADDR);
  wire isId = (rxAddr == ID_ADDR);
  wire isOwn = ownOk & (rxAddr == slaveAddr_ff);
  wire isCmd = (shift_ff == RESET_CMD);

  // Acknowledge and next meaning for the byte just received
  logic ackDec;
  isa_ctx_e ctxDec;
  always_comb begin
    ackDec = 1'b0;
    ctxDec = CX_ADDR;
    case (ctx_ff)
      CX_ADDR: begin
        if (isGc) begin
          ackDec = ~rxRead;
          ctxDec = CX_GC;
        end else if (isId) begin
          ackDec = rxRead ? idArmed_ff : 1'b1;
          ctxDec = rxRead ? CX_IDRD : CX_IDSEL;
        end else if (isOwn) begin
          ackDec = 1'b1;
          ctxDec = CX_OWN;
        end
      end
      CX_GC: begin
        ackDec = isCmd;
        ctxDec = CX_GCX;
      end
      CX_GCX: begin
        ackDec = 1'b0;
        ctxDec = CX_GCX;
      end
      CX_IDSEL: begin
        ackDec = isOwn;
        ctxDec = CX_IDSEL;
      end
      default: begin
        ackDec = 1'b0;
        ctxDec = CX_ADDR;
      end
    endcase
  end

  // Identity bytes, manufacturer first
  wire [23:0] idWord = DEV_ID;
  wire [1:0] idIdxNext = (idIdx_ff == ID_LAST_IDX) ? 2'h0 : idIdx_ff + 2'h1;
  wire [7:0] idByteNext = (idIdxNext == 2'h0) ? idWord[23:16] :
                          (idIdxNext == 2'h1) ? idWord[15:8] : idWord[7:0];
  wire [7:0] idByteFirst = idWord[23:16];

  ////////////////////////////////////////////////////////////////////////////////
  // Slave sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_ctx = ctx_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_sdaOe = sdaOe_ff;
    nxt_gcArmed = gcArmed_ff;
    nxt_idArmed = idArmed_ff;
    nxt_idIdx = idIdx_ff;
    nxt_mackNack = mackNack_ff;
    nxt_swRst = 1'b0;
    nxt_ownHit = 1'b0;
    if (ev.stop) begin
      nxt_state = ST_IDLE;
      nxt_sdaOe = 1'b0;
      nxt_swRst = gcArmed_ff;
      nxt_gcArmed = 1'b0;
      nxt_idArmed = 1'b0;
    end else if (ev.start) begin
      nxt_state = ST_RX;
      nxt_ctx = CX_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_sdaOe = 1'b0;
      nxt_gcArmed = 1'b0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (ev.sclRise) begin
            nxt_shift = {shift_ff[6:0], sdaS};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end else if (ev.sclFall && bitCnt_ff == RX_BITS) begin
            nxt_state = ST_ACK;
            nxt_sdaOe = ackDec;
            nxt_ctx = ctxDec;
            if (ctx_ff == CX_GC) begin
              nxt_gcArmed = ackDec;
            end
            if (ctx_ff == CX_GCX) begin
              nxt_gcArmed = 1'b0;
            end
            if (ctx_ff == CX_IDSEL) begin
              nxt_idArmed = ackDec;
            end
            if (ctx_ff == CX_ADDR && !isId) begin
              nxt_idArmed = 1'b0;
            end
            if (ctx_ff == CX_ADDR && !isGc && !isId && isOwn) begin
              nxt_ownHit = 1'b1;
            end
          end
        end
        ST_ACK: begin
          if (ev.sclFall) begin
            nxt_sdaOe = 1'b0;
            nxt_bitCnt = 4'h0;
            if (!sdaOe_ff) begin
              nxt_state = ST_IDLE;
            end else if (ctx_ff == CX_GC || ctx_ff == CX_GCX || ctx_ff == CX_IDSEL) begin
              nxt_state = ST_RX;
            end else if (ctx_ff == CX_IDRD) begin
              nxt_state = ST_TX;
              nxt_idIdx = 2'h0;
              nxt_shift = idByteFirst;
              nxt_sdaOe = ~idByteFirst[7];
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_TX: begin
          if (ev.sclFall) begin
            if (bitCnt_ff == TX_LAST) begin
              nxt_state = ST_MACK;
              nxt_sdaOe = 1'b0;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_bitCnt = bitCnt_ff + 4'h1;
              nxt_sdaOe = ~shift_ff[6];
            end
          end
        end
        ST_MACK: begin
          if (ev.sclRise) begin
            nxt_mackNack = sdaS;
          end else if (ev.sclFall) begin
            nxt_bitCnt = 4'h0;
            if (mackNack_ff) begin
              nxt_state = ST_IDLE;
              nxt_idArmed = 1'b0;
            end else begin
              nxt_state = ST_TX;
              nxt_idIdx = idIdxNext;
              nxt_shift = idByteNext;
              nxt_sdaOe = ~idByteNext[7];
            end
          end
        end
        default: begin
          nxt_sdaOe = 1'b0;
        end
      endcase
    end
  end

  // Soft reset puts the sequencer back to its power-up state one cycle after STOP
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      ctx_ff <= CX_ADDR;
      bitCnt_ff <= 4'h0;
      shift_ff <= BYTE_RST;
      sdaOe_ff <= 1'b0;
      gcArmed_ff <= 1'b0;
      idArmed_ff <= 1'b0;
      idIdx_ff <= 2'h0;
      mackNack_ff <= 1'b0;
      swRst_ff <= 1'b0;
      ownHit_ff <= 1'b0;
    end else if (swRst_ff) begin
      state_ff <= ST_IDLE;
      ctx_ff <= CX_ADDR;
      bitCnt_ff <= 4'h0;
      shift_ff <= BYTE_RST;
      sdaOe_ff <= 1'b0;
      gcArmed_ff <= 1'b0;
      idArmed_ff <= 1'b0;
      idIdx_ff <= 2'h0;
      mackNack_ff <= 1'b0;
      swRst_ff <= 1'b0;
      ownHit_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ctx_ff <= nxt_ctx;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      sdaOe_ff <= nxt_sdaOe;
      gcArmed_ff <= nxt_gcArmed;
      idArmed_ff <= nxt_idArmed;
      idIdx_ff <= nxt_idIdx;
      mackNack_ff <= nxt_mackNack;
      swRst_ff <= nxt_swRst;
      ownHit_ff <= nxt_ownHit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs; SDA is open drain, so the driven level is always low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_ff;
  assign slaveAddr = slaveAddr_ff;
  assign addrValid = addrValid_ff;
  assign softResetPulse = swRst_ff;
  assign ownAddrHit = ownHit_ff;

endmodule : isa_i2c_slave

// ### rtl/isa_pkg.sv
// Package for the I2C slave front end: address decode, software reset, identity read.
// Assumes a single system clock; all bus pins are asynchronous to it.
package isa_pkg;

  // Reserved seven-bit addresses and the reset command byte
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [6:0] ID_ADDR = 7'h7C;
  localparam logic [7:0] RESET_CMD = 8'h06;

  // Bit counts within one byte transfer
  localparam logic [3:0] RX_BITS = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;

  // Identity word is three bytes long; index of the last byte
  localparam logic [1:0] ID_LAST_IDX = 2'h2;

  // Upper nibble of the slave address, indexed by which straps sit on a bus line.
  // Index bit 2 = strap 2 on SCL/SDA, bit 1 = strap 1, bit 0 = strap 0; nibble n at bits 4n+3..4n.
  localparam logic [31:0] ADDR_HI_TAB = 32'hA8EC_3254;

  // Reset values
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [11:0] MIS_RST = 12'h000;

  // Strap state; bit 0 is the address bit, bit 1 tells a bus line from a supply rail
  typedef enum logic [1:0] {TIE_GND, TIE_VDD, TIE_SCL, TIE_SDA} isa_tie_e;

  // Slave sequencer phase and the meaning of the byte in progress
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} isa_state_e;
  typedef enum logic [2:0] {CX_ADDR, CX_GC, CX_GCX, CX_IDSEL, CX_IDRD, CX_OWN} isa_ctx_e;

  // Identity word, sent most significant byte first
  typedef struct packed {
    logic [7:0] mfr;
    logic [6:0] category;
    logic [5:0] feature;
    logic [2:0] rev;
  } isa_devid_s;

  // Bus conditions seen on the synchronised lines, each a one-cycle pulse
  typedef struct packed {
    logic start;
    logic stop;
    logic sclRise;
    logic sclFall;
  } isa_busev_s;

endpackage : isa_pkg

// ### tb/isa_i2c_master.sv
// I2C master model: pulls SCL and SDA low as an open-drain driver.
// Assumes pull-ups; a released line reads high. SCL period is 12 clk.
module isa_i2c_master (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sdaWire,
  output logic sclLow,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  ////////////////////////////////////////
  task automatic q();
    repeat (3) @(posedge clk);
  endtask : q
  // Start and repeated start; SCL is left low
  task automatic start();
    sdaLow <= 1'b0;
    q();
    sclLow <= 1'b0;
    q();
    sdaLow <= 1'b1;
    q();
    sclLow <= 1'b1;
    q();
  endtask : start
  task automatic stop();
    sdaLow <= 1'b1;
    q();
    sclLow <= 1'b0;
    q();
    sdaLow <= 1'b0;
    q();
  endtask : stop
  // SDA only moves while SCL is low; sampled mid-high, off the edge
  task automatic bitIo(input logic b, output logic r);
    sdaLow <= !b;
    q();
    sclLow <= 1'b0;
    q();
    #1 r = sdaWire;
    q();
    sclLow <= 1'b1;
    q();
  endtask : bitIo
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(d[i], r);
    bitIo(1'b1, r);
    ack = !r;
  endtask : sendByte
  task automatic readByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(!ackIt, r);
  endtask : readByte
endmodule : isa_i2c_master

// ### tb/isa_i2c_slave_sva.sv
// Port assertions for the I2C slave front end.
// Assumes sclIn and sdaIn are the resolved wire levels.
module isa_i2c_slave_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOe,
  // Status
  input wire logic [6:0] slaveAddr,
  input wire logic addrValid,
  input wire logic softResetPulse,
  input wire logic ownAddrHit
);
  timeunit 1ns;
  timeprecision 100ps;
  import isa_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Saturating ages of the last raw STOP and the last driven slot
  logic sdaLast_ff;
  logic [7:0] stopAge_ff;
  logic [7:0] oeAge_ff;
  logic stopNow;
  logic [7:0] nxt_stopAge;
  logic [7:0] nxt_oeAge;
  assign stopNow = sclIn && sdaIn && !sdaLast_ff;
  assign nxt_stopAge = stopNow ? 8'h00 : stopAge_ff + {7'h00, stopAge_ff != 8'hFF};
  assign nxt_oeAge = sdaOe ? 8'h00 : oeAge_ff + {7'h00, oeAge_ff != 8'hFF};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdaLast_ff <= 1'b1;
      stopAge_ff <= 8'hFF;
      oeAge_ff <= 8'hFF;
    end else begin
      sdaLast_ff <= sdaIn;
      stopAge_ff <= nxt_stopAge;
      oeAge_ff <= nxt_oeAge;
    end
  end
  ////////////////////////////////////////
  sequence busStop;
    sclIn && $rose(sdaIn);
  endsequence
  sequence oeSlot;
    sdaOe [*8];
  endsequence
  oe_change_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("SDA drive moved while SCL high");
  oe_slot_a: assert property ($rose(sdaOe) |-> oeSlot)
    else $error("SDA drive shorter than a bit slot");
  stop_free_a: assert property (busStop |-> !sdaOe [*8])
    else $error("SDA driven after STOP");
  reset_stop_a: assert property (softResetPulse |-> stopAge_ff <= 8'h10)
    else $error("Soft reset without a STOP");
  reset_clear_a: assert property (softResetPulse |=> !addrValid && slaveAddr == ADDR_RST)
    else $error("State kept after soft reset");
  addr_hold_a: assert property (addrValid && $past(addrValid) |-> $stable(slaveAddr))
    else $error("Slave address moved");
  addr_zero_a: assert property (!addrValid |-> slaveAddr == ADDR_RST)
    else $error("Address shown before decode");
  own_reserved_a: assert property (ownAddrHit |-> addrValid && slaveAddr != GC_ADDR && slaveAddr != ID_ADDR)
    else $error("Own hit on reserved address");
  own_ack_a: assert property (ownAddrHit |-> (oeAge_ff <= 8'h0E) or (##[0:14] sdaOe))
    else $error("Own hit without acknowledge");
endmodule : isa_i2c_slave_sva

bind isa_i2c_slave isa_i2c_slave_sva sva_u (
  .clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe), .slaveAddr(slaveAddr),
  .addrValid(addrValid), .softResetPulse(softResetPulse), .ownAddrHit(ownAddrHit)
);

// ### tb/isa_i2c_slave_tb.sv
// Self-checking bench for the I2C slave front end.
// Assumes the master model and the checker are compiled first.
module isa_i2c_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import isa_pkg::*;
  // Identity fields are arbitrary
  localparam logic [7:0] ID_MFR = 8'h3B;
  localparam logic [6:0] ID_CAT = 7'h25;
  localparam logic [5:0] ID_FEAT = 6'h0A;
  localparam logic [2:0] ID_REV = 3'h5;
  localparam logic [23:0] ID_WORD = {ID_MFR, ID_CAT, ID_FEAT, ID_REV};
  localparam int LIMIT = 30000;
  logic clk;
  logic rst = 1'b1;
  logic [1:0] t0 = TIE_GND;
  logic [1:0] t1 = TIE_GND;
  logic [1:0] t2 = TIE_SCL;
  logic mSclLow, mSdaLow, sclW, sdaW, strap0, strap1, strap2;
  logic sdaOut, sdaOe, addrValid, softResetPulse, ownAddrHit;
  logic [6:0] slaveAddr;
  logic [7:0] ownB;
  int err_count = 0;
  int cmp_count = 0;
  int cycCount = 0;
  int hitCnt = 0;
  int rstCnt = 0;
  function automatic logic tieLvl(input logic [1:0] t, input logic c, input logic d);
    return t[1] ? (t[0] ? d : c) : t[0];
  endfunction : tieLvl
  // Strap 2 on SCL/SDA, strap 1 on a rail: C0h up to EEh
  function automatic logic [7:0] expByte(input logic [1:0] a2, a1, a0);
    return {2'b11, a0[1], 1'b0, a2[0], a1[0], a0[0], 1'b0};
  endfunction : expByte
  assign sclW = !mSclLow;
  assign sdaW = !(mSdaLow || (sdaOe && !sdaOut));
  assign strap0 = tieLvl(t0, sclW, sdaW);
  assign strap1 = tieLvl(t1, sclW, sdaW);
  assign strap2 = tieLvl(t2, sclW, sdaW);
  isa_i2c_slave #(.DEV_ID(ID_WORD)) dut_u (
    .clk(clk), .rst(rst), .sclIn(sclW), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrStrap0(strap0), .addrStrap1(strap1), .addrStrap2(strap2), .slaveAddr(slaveAddr),
    .addrValid(addrValid), .softResetPulse(softResetPulse), .ownAddrHit(ownAddrHit)
  );
  isa_i2c_master mst_u (.clk(clk), .sdaWire(sdaW), .sclLow(mSclLow), .sdaLow(mSdaLow));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  // Pulses are counted so that no one-cycle pulse is missed
  always @(posedge clk) begin
    cycCount <= cycCount + 1;
    hitCnt <= hitCnt + int'(ownAddrHit === 1'b1);
    rstCnt <= rstCnt + int'(softResetPulse === 1'b1);
    if (cycCount == LIMIT) begin
      err_count++;
      complete_run();
    end
  end
  task automatic tx(input logic [7:0] b, input logic expAck);
    logic a;
    mst_u.sendByte(b, a);
    chk1(a, expAck);
  endtask : tx
  task automatic strapReset(input logic [1:0] a2, a1, a0);
    @(posedge clk);
    t2 <= a2;
    t1 <= a1;
    t0 <= a0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    ownB = expByte(a2, a1, a0);
  endtask : strapReset
  // Mode 1 adds a byte after the command, mode 2 restarts and addresses the own slave before stopping
  task automatic gcSeq(input logic [7:0] cmd, input logic cmdOk, input logic [1:0] mode, input logic expRst);
    int r0;
    r0 = rstCnt;
    mst_u.start();
    tx({GC_ADDR, 1'b0}, 1'b1);
    tx(cmd, cmdOk);
    if (mode == 2'h1) tx(8'($urandom), 1'b0);
    if (mode == 2'h2) begin
      mst_u.start();
      tx(ownB, 1'b1);
    end
    mst_u.stop();
    repeat (12) @(posedge clk);
    chk1(rstCnt != r0, expRst);
    if (expRst) chk1(addrValid, 1'b0);
  endtask : gcSeq
  task automatic idRead(input logic [7:0] selB, input logic selAck, input logic viaStop, input int n);
    logic [7:0] d;
    mst_u.start();
    tx({ID_ADDR, 1'b0}, 1'b1);
    tx(selB, selAck);
    if (viaStop) mst_u.stop();
    mst_u.start();
    tx({ID_ADDR, 1'b1}, n > 0);
    for (int k = 0; k < n; k++) begin
      mst_u.readByte(k < n - 1, d);
      chk8(d, ID_WORD[8 * (2 - k % 3) +: 8]);
    end
    mst_u.stop();
  endtask : idRead
  ////////////////////////////////////////
  initial begin
    logic [1:0] a0, a1, a2;
    int h0;
    void'($urandom(5007));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      a2 = (i < 2) ? {1'b1, i[0]} : {1'b1, 1'($urandom_range(1))};
      a1 = (i < 2) ? {1'b0, i[0]} : {1'b0, 1'($urandom_range(1))};
      a0 = (i < 2) ? {i[0], i[0]} : 2'($urandom_range(3));
      strapReset(a2, a1, a0);
      h0 = hitCnt;
      mst_u.start();
      tx(ownB | 8'(i % 2), 1'b1);
      mst_u.stop();
      chk1(hitCnt == h0 + 1, 1'b1);
      chk8({slaveAddr, 1'b0}, ownB);
      mst_u.start();
      tx(ownB ^ 8'h02, 1'b0);
      mst_u.stop();
    end
    h0 = rstCnt;
    mst_u.start();
    tx({GC_ADDR, 1'b1}, 1'b0);
    mst_u.stop();
    chk1(rstCnt == h0, 1'b1);
    gcSeq(8'h06 ^ 8'($urandom_range(255, 1)), 1'b0, 2'h0, 1'b0);
    gcSeq(RESET_CMD, 1'b1, 2'h1, 1'b0);
    gcSeq(RESET_CMD, 1'b1, 2'h2, 1'b0);
    gcSeq(RESET_CMD, 1'b1, 2'h0, 1'b1);
    idRead(ownB | 8'($urandom_range(1)), 1'b1, 1'b0, 1);
    idRead(ownB, 1'b1, 1'b0, 5);
    idRead(ownB ^ 8'h04, 1'b0, 1'b0, 0);
    idRead(ownB, 1'b1, 1'b1, 0);
    complete_run();
  end
endmodule : isa_i2c_slave_tb
